// File: verilog/rip_pkg.sv
// Purpose: Shared constants, field layout and helpers of the integer pipeline
// Assumes: Instruction word laid out by the field positions below
// Notes:   Opcode and trap encodings are local to this unit
`default_nettype none
package rip_pkg;
	typedef logic [31:0] rip_word_t;
	// Opcode classes
	localparam logic [3:0] OP_ALU  = 4'h0;
	localparam logic [3:0] OP_LD   = 4'h1;
	localparam logic [3:0] OP_ST   = 4'h2;
	localparam logic [3:0] OP_BR   = 4'h3;
	localparam logic [3:0] OP_CALL = 4'h4;
	localparam logic [3:0] OP_JMPL = 4'h5;
	localparam logic [3:0] OP_RETT = 4'h6;
	localparam logic [3:0] OP_NOP  = 4'h7;
	localparam logic [3:0] OP_JABS = 4'h8;
	// Field positions
	localparam int OPC_LSB   = 28;
	localparam int RD_LSB    = 23;
	localparam int ANNUL_BIT = 27;
	localparam int COND_LSB  = 23;
	localparam int RS1_LSB   = 18;
	localparam int IMM_BIT   = 17;
	localparam int FN_LSB    = 13;
	localparam int SIZE_LSB  = 13;
	localparam int SIGN_BIT  = 15;
	localparam int RS2_LSB   = 0;
	localparam int ICC_MSB   = 23;
	localparam int ICC_LSB   = 20;
	localparam int TBA_LSB   = 12;
	localparam int TT_LSB    = 4;
	// Condition flag positions
	localparam int ICC_N = 3;
	localparam int ICC_Z = 2;
	localparam int ICC_V = 1;
	localparam int ICC_C = 0;
	// ALU functions, bit 3 of the field sets flags
	localparam int          FN_CC_BIT = 3;
	localparam logic [2:0] FN_ADD = 3'h0;
	localparam logic [2:0] FN_SUB = 3'h1;
	localparam logic [2:0] FN_AND = 3'h2;
	localparam logic [2:0] FN_OR  = 3'h3;
	localparam logic [2:0] FN_XOR = 3'h4;
	localparam logic [2:0] FN_SLL = 3'h5;
	localparam logic [2:0] FN_SRL = 3'h6;
	localparam logic [2:0] FN_SRA = 3'h7;
	// Access sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	// Trap codes
	localparam logic [7:0] TT_ILLEGAL = 8'h02;
	localparam logic [7:0] TT_ALIGN   = 8'h07;
	localparam logic [7:0] TT_ASYNC   = 8'h1f;
	// Misc values
	localparam logic [4:0] LINK_REG = 5'h0f;
	localparam rip_word_t  RST_PC   = 32'h0000_0000;
	localparam rip_word_t  PC_STEP  = 32'h0000_0004;

	function automatic rip_word_t rip_shift(input rip_word_t v, input logic [4:0] amt,
		input logic right, input logic arith);
		logic [63:0] ext;
		ext = {{32{arith & v[31]}}, v};
		if (right) begin
			return ext[amt +: 32];
		end
		return 32'(v << amt);
	endfunction : rip_shift

	function automatic logic [4:0] rip_lane(input logic [1:0] alo, input logic [1:0] size);
		if (size == SZ_BYTE) begin
			return {~alo, 3'h0};
		end
		if (size == SZ_HALF) begin
			return {~alo[1], 4'h0};
		end
		return 5'h00;
	endfunction : rip_lane

	function automatic rip_word_t rip_agu(input rip_word_t ir, input rip_word_t pc,
		input rip_word_t ra, input rip_word_t rb);
		unique case (ir[OPC_LSB +: 4])
			OP_CALL: return pc + {{2{ir[27]}}, ir[27:0], 2'h0};
			OP_JABS: return {7'h00, ir[22:0], 2'h0};
			OP_BR:   return pc + {{7{ir[22]}}, ir[22:0], 2'h0};
			default: return ir[IMM_BIT] ? ra + {{19{ir[12]}}, ir[12:0]} : ra + rb;
		endcase
	endfunction : rip_agu

	function automatic logic rip_cond(input logic [3:0] c, input logic [3:0] icc);
		logic s;
		s = 1'b0;
		unique case (c[2:0])
			3'h0: s = 1'b0;
			3'h1: s = icc[ICC_Z];
			3'h2: s = icc[ICC_N];
			3'h3: s = icc[ICC_C];
			3'h4: s = icc[ICC_V];
			3'h5: s = icc[ICC_N] ^ icc[ICC_V];
			3'h6: s = icc[ICC_Z] | (icc[ICC_N] ^ icc[ICC_V]);
			3'h7: s = icc[ICC_C] | icc[ICC_Z];
		endcase
		return s ^ c[3];
	endfunction : rip_cond
endpackage : rip_pkg
`default_nettype wire

// File: verilog/rip_alu.sv
// Purpose: One-cycle integer ALU with barrel shifter
// Assumes: Operands from the operand registers
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module rip_alu import rip_pkg::*; (
	// Operands
	input  wire logic [31:0] opa,
	input  wire logic [31:0] opb,
	input  wire logic [2:0]  fn,
	// Results
	output logic      [31:0] y,
	output logic      [3:0]  flags
);
	logic [32:0] sum;
	logic        ovf;

	always_comb begin
		sum = {1'b0, opa} + {1'b0, opb};
		ovf = 1'b0;
		y = sum[31:0];
		unique case (fn)
			FN_ADD: ovf = (opa[31] == opb[31]) && (y[31] != opa[31]);
			FN_SUB: begin
				sum = {1'b0, opa} - {1'b0, opb};
				y = sum[31:0];
				ovf = (opa[31] != opb[31]) && (y[31] != opa[31]);
			end
			FN_AND: y = opa & opb;
			FN_OR:  y = opa | opb;
			FN_XOR: y = opa ^ opb;
			FN_SLL: y = rip_shift(opa, opb[4:0], 1'b0, 1'b0);
			FN_SRL: y = rip_shift(opa, opb[4:0], 1'b1, 1'b0);
			FN_SRA: y = rip_shift(opa, opb[4:0], 1'b1, 1'b1);
		endcase
		flags[ICC_N] = y[31];
		flags[ICC_Z] = (y == 32'h0000_0000);
		flags[ICC_V] = ovf;
		flags[ICC_C] = (fn == FN_ADD || fn == FN_SUB) && sum[32];
	end
endmodule : rip_alu
`default_nettype wire

// File: verilog/rip_align.sv
// Purpose: Load data aligner
// Assumes: Big-endian lanes, byte 0 is most significant
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module rip_align import rip_pkg::*; (
	// Raw word and access shape
	input  wire logic [31:0] word,
	input  wire logic [1:0]  alo,
	input  wire logic [1:0]  size,
	input  wire logic        sgn,
	// Aligned value
	output logic      [31:0] data
);
	logic [31:0] sh;

	always_comb begin
		sh = rip_shift(word, rip_lane(alo, size), 1'b1, 1'b0);
		unique case (size)
			SZ_BYTE: data = {{24{sgn & sh[7]}}, sh[7:0]};
			SZ_HALF: data = {{16{sgn & sh[15]}}, sh[15:0]};
			default: data = word;
		endcase
	end
endmodule : rip_align
`default_nettype wire

// File: verilog/rip_pipe.sv
// Purpose: Four-stage integer pipeline control and execution datapath
// Assumes: Instruction and data memories answer as described at the ports
// Notes:   Freeze on either hold input; traps taken in the write stage
//
// Notes on behaviour
// - Fetch, decode, execute, write stages; one instruction may enter per cycle.
// - Two-entry instruction buffer keeps fetching while decode is held by a load-use stall.
// - A trapping instruction never writes the register file.
// - A use right after a load of that register gets a one-cycle bubble.
// - The instruction after any control transfer is always fetched as delay slot.
// - Control transfers drop any buffered instruction after the delay slot; fetch changes path.
// - Annul bit on a not-taken branch turns its delay slot into a no-op.
// - Either hold input freezes the whole pipeline with execute held.
// - Synchronous traps win over asynchronous; taken only in write stage.
// - Taking a trap annuls all younger instructions, then fetches the handler.
// - ALU finishes in one cycle and updates the icc flags, state bits 23:20.
// - Operand registers load from register file, a bypass, or an immediate.
// - ALU output goes to a result register; only load data passes the aligner.
// - Dependence on the previous instruction takes the raw ALU output.
// - Dependence two instructions back takes the write-stage value: result register, or aligned load data after a load.
// - Loads place bytes and halfwords in the aligner before write-back.
// - Barrel shifter shifts a 32-bit value by a count in one cycle.
// - Stores shift bytes and halfwords onto their data bus lanes.
// - A separate address unit forms addresses per instruction format.
// - Trap handler address is formed from the trap base value.
// - Four program counters; current and next are saved on trap entry.
`timescale 1ns/1ps
`default_nettype none
module rip_pipe import rip_pkg::*; (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// Instruction fetch
	output logic      [31:0] inst_addr,
	output logic             inst_req,
	input  wire logic        inst_ready,
	input  wire logic [31:0] inst_rdata,
	// Data memory
	output logic             data_req,
	output logic             data_we,
	output logic      [31:0] data_addr,
	output logic      [31:0] data_wdata,
	output logic      [1:0]  data_size,
	input  wire logic [31:0] data_rdata,
	// Holds and traps
	input  wire logic        memory_hold_in,
	input  wire logic        bus_hold_in,
	input  wire logic        async_trap_in,
	input  wire logic [31:0] trap_vector_base,
	// Status
	output logic             trap_taken,
	output logic      [7:0]  trap_type,
	output logic      [31:0] saved_pc,
	output logic      [31:0] saved_npc,
	output logic      [31:0] proc_state
);
	// Fetch and buffer
	rip_word_t   next_prog_counter_reg;
	rip_word_t   redir_tgt_reg;
	logic        redir_reg;
	rip_word_t   buf_ir_reg [2];
	rip_word_t   buf_pc_reg [2];
	logic [1:0]  cnt_reg;
	// Decode
	logic        dec_v_reg;
	rip_word_t   dec_ir_reg;
	rip_word_t   dec_pc_reg;
	logic        ann_reg;
	// Execute
	logic        ex_v_reg;
	rip_word_t   ex_pc_reg;
	logic [4:0]  ex_rd_reg;
	logic        ex_wen_reg;
	logic        ex_ld_reg;
	logic        ex_st_reg;
	logic        ex_cc_reg;
	logic [2:0]  ex_fn_reg;
	logic        ex_tr_reg;
	logic [7:0]  ex_tt_reg;
	rip_word_t   opa_reg;
	rip_word_t   opb_reg;
	rip_word_t   ex_addr_reg;
	rip_word_t   ex_wdata_reg;
	logic [1:0]  ex_size_reg;
	logic        ex_sgn_reg;
	// Write
	logic        wr_v_reg;
	rip_word_t   wr_pc_reg;
	logic [4:0]  wr_rd_reg;
	logic        wr_wen_reg;
	logic        wr_ld_reg;
	logic        wr_cc_reg;
	logic        wr_tr_reg;
	logic [7:0]  wr_tt_reg;
	logic [1:0]  wr_size_reg;
	logic        wr_sgn_reg;
	logic [1:0]  wr_alo_reg;
	logic [3:0]  wr_icc_reg;
	rip_word_t   res_reg;
	// Architectural state
	logic [3:0]  icc_reg;
	rip_word_t   saved_pc_reg;
	rip_word_t   saved_npc_reg;
	logic [7:0]  trap_type_reg;
	rip_word_t   rf [32];
	// Combinational
	logic        freeze;
	logic        take_trap;
	logic [7:0]  trap_code;
	rip_word_t   trap_vec;
	logic        lu_stall;
	logic        dec_go;
	logic        br_now;
	logic        fetch_acc;
	logic        src_v;
	rip_word_t   src_ir;
	rip_word_t   src_pc;
	logic [3:0]  d_op;
	logic [4:0]  d_rs1;
	logic [4:0]  d_rs2;
	logic [4:0]  d_rd;
	logic        d_imm;
	logic        d_link;
	logic        d_ctrl;
	logic        d_useregs;
	logic        d_taken;
	logic        d_mis;
	logic        d_ill;
	logic        fwd_ex_a;
	logic        fwd_wr_a;
	rip_word_t   d_ra;
	rip_word_t   d_rb;
	rip_word_t   d_rdv;
	rip_word_t   d_addr;
	logic [1:0]  d_size;
	logic [3:0]  icc_fwd;
	rip_word_t   alu_y;
	logic [3:0]  alu_flags;
	rip_word_t   ld_data;
	rip_word_t   wb_data;
	logic        rf_we;

	function automatic logic ex_hit(input logic [4:0] rs);
		return ex_v_reg && ex_wen_reg && ex_rd_reg == rs && rs != 5'h00;
	endfunction : ex_hit

	function automatic logic wr_hit(input logic [4:0] rs);
		return wr_v_reg && wr_wen_reg && wr_rd_reg == rs && rs != 5'h00;
	endfunction : wr_hit

	// Operand select with both bypasses
	function automatic rip_word_t fwd(input logic [4:0] rs);
		if (rs == 5'h00) begin
			return 32'h0000_0000;
		end
		if (ex_hit(rs) && !ex_ld_reg) begin
			return alu_y;
		end
		if (wr_hit(rs)) begin
			return wb_data;
		end
		return rf[rs];
	endfunction : fwd

	rip_alu u_alu (
		.opa   (opa_reg),
		.opb   (opb_reg),
		.fn    (ex_fn_reg),
		.y     (alu_y),
		.flags (alu_flags)
	);

	rip_align u_align (
		.word (data_rdata),
		.alo  (wr_alo_reg),
		.size (wr_size_reg),
		.sgn  (wr_sgn_reg),
		.data (ld_data)
	);

	// Pipeline control
	always_comb begin
		wb_data = wr_ld_reg ? ld_data : res_reg;
		freeze = memory_hold_in | bus_hold_in;
		take_trap = wr_v_reg && (wr_tr_reg || async_trap_in) && !freeze;
		trap_code = wr_tr_reg ? wr_tt_reg : TT_ASYNC;
		trap_vec = {trap_vector_base[31:TBA_LSB], trap_code, {TT_LSB{1'b0}}};
		d_op = dec_ir_reg[OPC_LSB +: 4];
		d_rs1 = dec_ir_reg[RS1_LSB +: 5];
		d_rs2 = dec_ir_reg[RS2_LSB +: 5];
		d_rd = dec_ir_reg[RD_LSB +: 5];
		d_imm = dec_ir_reg[IMM_BIT];
		d_size = dec_ir_reg[SIZE_LSB +: 2];
		d_link = d_op == OP_CALL || d_op == OP_JMPL;
		d_ctrl = d_link || d_op == OP_BR || d_op == OP_RETT || d_op == OP_JABS;
		d_useregs = d_op == OP_ALU || d_op == OP_LD || d_op == OP_ST
			|| d_op == OP_JMPL || d_op == OP_RETT;
		d_ill = d_op > OP_JABS;
		d_ra = fwd(d_rs1);
		d_rb = fwd(d_rs2);
		d_rdv = fwd(d_rd);
		fwd_ex_a = ex_hit(d_rs1) && !ex_ld_reg;
		fwd_wr_a = !ex_hit(d_rs1) && wr_hit(d_rs1);
		d_addr = rip_agu(dec_ir_reg, dec_pc_reg, d_ra, d_rb);
		d_mis = (d_op == OP_LD || d_op == OP_ST)
			&& ((d_size == SZ_HALF && d_addr[0]) || (d_size == SZ_WORD && d_addr[1:0] != 2'h0));
		icc_fwd = icc_reg;
		if (ex_v_reg && ex_cc_reg) begin
			icc_fwd = alu_flags;
		end else if (wr_v_reg && wr_cc_reg) begin
			icc_fwd = wr_icc_reg;
		end
		d_taken = d_op == OP_BR ? rip_cond(dec_ir_reg[COND_LSB +: 4], icc_fwd) : d_ctrl;
		lu_stall = dec_v_reg && ex_v_reg && ex_ld_reg && ((d_useregs && ex_hit(d_rs1))
			|| (d_useregs && !d_imm && ex_hit(d_rs2))
			|| (d_op == OP_ST && ex_hit(d_rd)));
		dec_go = !freeze && !take_trap && !lu_stall;
		br_now = dec_v_reg && dec_go && d_ctrl && d_taken && !ann_reg;
		inst_req = !freeze && !take_trap && cnt_reg != 2'h2 && !(br_now && cnt_reg != 2'h0);
		fetch_acc = inst_req && inst_ready;
		src_v = cnt_reg != 2'h0 || fetch_acc;
		src_ir = cnt_reg != 2'h0 ? buf_ir_reg[0] : inst_rdata;
		src_pc = cnt_reg != 2'h0 ? buf_pc_reg[0] : next_prog_counter_reg;
		rf_we = wr_v_reg && wr_wen_reg && !take_trap && !freeze;
	end

	// Fetch counter and delayed redirect
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			next_prog_counter_reg <= RST_PC;
			redir_tgt_reg <= RST_PC;
			redir_reg <= 1'b0;
		end else if (take_trap) begin
			next_prog_counter_reg <= trap_vec;
			redir_reg <= 1'b0;
		end else if (br_now) begin
			if (cnt_reg != 2'h0 || fetch_acc) begin
				next_prog_counter_reg <= d_addr;
			end else begin
				redir_reg <= 1'b1;
				redir_tgt_reg <= d_addr;
			end
		end else if (fetch_acc) begin
			next_prog_counter_reg <= redir_reg ? redir_tgt_reg : next_prog_counter_reg + PC_STEP;
			redir_reg <= 1'b0;
		end
	end

	// Instruction buffer
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= 2'h0;
			for (int i = 0; i < 2; i++) begin
				buf_ir_reg[i] <= 32'h0000_0000;
				buf_pc_reg[i] <= RST_PC;
			end
		end else if (take_trap) begin
			cnt_reg <= 2'h0;
		end else if (br_now && cnt_reg != 2'h0) begin
			cnt_reg <= 2'h0;
		end else begin
			unique case ({dec_go && cnt_reg != 2'h0, fetch_acc && !(dec_go && cnt_reg == 2'h0)})
				2'b10: begin
					buf_ir_reg[0] <= buf_ir_reg[1];
					buf_pc_reg[0] <= buf_pc_reg[1];
					cnt_reg <= cnt_reg - 2'h1;
				end
				2'b01: begin
					buf_ir_reg[cnt_reg[0]] <= inst_rdata;
					buf_pc_reg[cnt_reg[0]] <= next_prog_counter_reg;
					cnt_reg <= cnt_reg + 2'h1;
				end
				2'b11: begin
					buf_ir_reg[0] <= inst_rdata;
					buf_pc_reg[0] <= next_prog_counter_reg;
				end
				default: begin
				end
			endcase
		end
	end

	// Decode stage
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dec_v_reg <= 1'b0;
			dec_ir_reg <= 32'h0000_0000;
			dec_pc_reg <= RST_PC;
			ann_reg <= 1'b0;
		end else if (take_trap) begin
			dec_v_reg <= 1'b0;
			ann_reg <= 1'b0;
		end else if (dec_go) begin
			dec_v_reg <= src_v;
			if (src_v) begin
				dec_ir_reg <= src_ir;
				dec_pc_reg <= src_pc;
			end
			if (dec_v_reg) begin
				ann_reg <= d_op == OP_BR && dec_ir_reg[ANNUL_BIT] && !d_taken;
			end
		end
	end

	// Execute stage
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ex_v_reg <= 1'b0;
			ex_pc_reg <= RST_PC;
			ex_rd_reg <= 5'h00;
			ex_wen_reg <= 1'b0;
			ex_ld_reg <= 1'b0;
			ex_st_reg <= 1'b0;
			ex_cc_reg <= 1'b0;
			ex_fn_reg <= FN_ADD;
			ex_tr_reg <= 1'b0;
			ex_tt_reg <= 8'h00;
			opa_reg <= 32'h0000_0000;
			opb_reg <= 32'h0000_0000;
			ex_addr_reg <= 32'h0000_0000;
			ex_wdata_reg <= 32'h0000_0000;
			ex_size_reg <= SZ_WORD;
			ex_sgn_reg <= 1'b0;
		end else if (take_trap) begin
			ex_v_reg <= 1'b0;
		end else if (!freeze) begin
			ex_v_reg <= dec_go && dec_v_reg && !ann_reg;
			if (dec_go) begin
				ex_pc_reg <= dec_pc_reg;
				ex_rd_reg <= d_op == OP_CALL ? LINK_REG : d_rd;
				ex_wen_reg <= d_link || d_op == OP_ALU || d_op == OP_LD;
				ex_ld_reg <= d_op == OP_LD;
				ex_st_reg <= d_op == OP_ST;
				ex_cc_reg <= d_op == OP_ALU && dec_ir_reg[FN_LSB + FN_CC_BIT];
				ex_fn_reg <= d_op == OP_ALU ? dec_ir_reg[FN_LSB +: 3] : FN_ADD;
				ex_tr_reg <= d_ill || d_mis;
				ex_tt_reg <= d_ill ? TT_ILLEGAL : TT_ALIGN;
				opa_reg <= d_link ? dec_pc_reg : d_ra;
				opb_reg <= d_link ? 32'h0000_0000 : d_imm
					? {{19{dec_ir_reg[12]}}, dec_ir_reg[12:0]} : d_rb;
				ex_addr_reg <= d_addr;
				ex_wdata_reg <= rip_shift(d_rdv, rip_lane(d_addr[1:0], d_size), 1'b0, 1'b0);
				ex_size_reg <= d_size;
				ex_sgn_reg <= dec_ir_reg[SIGN_BIT];
			end
		end
	end

	// Write stage
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wr_v_reg <= 1'b0;
			wr_pc_reg <= RST_PC;
			wr_rd_reg <= 5'h00;
			wr_wen_reg <= 1'b0;
			wr_ld_reg <= 1'b0;
			wr_cc_reg <= 1'b0;
			wr_tr_reg <= 1'b0;
			wr_tt_reg <= 8'h00;
			wr_size_reg <= SZ_WORD;
			wr_sgn_reg <= 1'b0;
			wr_alo_reg <= 2'h0;
			wr_icc_reg <= 4'h0;
			res_reg <= 32'h0000_0000;
		end else if (take_trap) begin
			wr_v_reg <= 1'b0;
		end else if (!freeze) begin
			wr_v_reg <= ex_v_reg;
			wr_pc_reg <= ex_pc_reg;
			wr_rd_reg <= ex_rd_reg;
			wr_wen_reg <= ex_wen_reg;
			wr_ld_reg <= ex_ld_reg;
			wr_cc_reg <= ex_cc_reg;
			wr_tr_reg <= ex_tr_reg;
			wr_tt_reg <= ex_tt_reg;
			wr_size_reg <= ex_size_reg;
			wr_sgn_reg <= ex_sgn_reg;
			wr_alo_reg <= ex_addr_reg[1:0];
			wr_icc_reg <= alu_flags;
			res_reg <= alu_y;
		end
	end

	// Register file
	always_ff @(posedge mclk) begin
		if (rf_we) begin
			rf[wr_rd_reg] <= wb_data;
		end
	end

	// Condition codes and trap state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			icc_reg <= 4'h0;
			saved_pc_reg <= RST_PC;
			saved_npc_reg <= RST_PC;
			trap_type_reg <= 8'h00;
		end else if (take_trap) begin
			saved_pc_reg <= wr_pc_reg;
			saved_npc_reg <= ex_v_reg ? ex_pc_reg : dec_v_reg ? dec_pc_reg
				: cnt_reg != 2'h0 ? buf_pc_reg[0] : next_prog_counter_reg;
			trap_type_reg <= trap_code;
		end else if (wr_v_reg && wr_cc_reg && !freeze) begin
			icc_reg <= wr_icc_reg;
		end
	end

	// Outputs
	always_comb begin
		inst_addr = next_prog_counter_reg;
		data_req = ex_v_reg && (ex_ld_reg || ex_st_reg) && !ex_tr_reg && !take_trap;
		data_we = ex_st_reg;
		data_addr = ex_addr_reg;
		data_wdata = ex_wdata_reg;
		data_size = ex_size_reg;
		trap_taken = take_trap;
		trap_type = trap_type_reg;
		saved_pc = saved_pc_reg;
		saved_npc = saved_npc_reg;
		proc_state = 32'h0000_0000;
		proc_state[ICC_MSB:ICC_LSB] = icc_reg;
	end

	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	hold_freeze_a: assert property (freeze |=> ex_pc_reg == $past(ex_pc_reg)
		&& wr_v_reg == $past(wr_v_reg) && dec_pc_reg == $past(dec_pc_reg))
		else $error("pipeline moved during hold");
	trap_nowrite_a: assert property (wr_v_reg && wr_tr_reg && !freeze
		|-> take_trap && !rf_we) else $error("trapping instruction wrote");
	load_bubble_a: assert property (lu_stall && !freeze && !take_trap
		|=> !ex_v_reg && dec_pc_reg == $past(dec_pc_reg)) else $error("no load-use bubble");
	slot_annul_a: assert property (ann_reg && dec_v_reg && dec_go
		|=> !ex_v_reg) else $error("delay slot not annulled");
	delay_fetch_a: assert property (br_now && cnt_reg == 2'h0
		|-> inst_addr == dec_pc_reg + PC_STEP) else $error("delay slot not fetched");
	trap_flush_a: assert property (take_trap |=> !dec_v_reg && !ex_v_reg
		&& !wr_v_reg && cnt_reg == 2'h0) else $error("younger not annulled");
	trap_vector_a: assert property (take_trap
		|=> inst_addr == $past(trap_vec) && trap_type == $past(trap_code))
		else $error("bad handler address");
	trap_save_a: assert property (take_trap |=> saved_pc == $past(wr_pc_reg))
		else $error("pc not saved");
	alu_bypass_a: assert property (dec_go && dec_v_reg && d_op == OP_ALU && fwd_ex_a
		|=> opa_reg == $past(alu_y)) else $error("alu bypass wrong");
	res_bypass_a: assert property (dec_go && dec_v_reg && d_op == OP_ALU && fwd_wr_a
		|=> opa_reg == $past(wb_data)) else $error("result bypass wrong");
endmodule : rip_pipe
`default_nettype wire

// File: sim/rip_mem_model.sv
// Purpose: Instruction and data memory partner with a memory hold source
// Assumes: Bench loads imem before releasing reset
// Notes:   slow adds fetch stalls and random memory holds
`timescale 1ns/1ps
`default_nettype none
module rip_mem_model (
	// Clock and mode
	input  wire logic        mclk,
	input  wire logic        slow,
	// Fetch
	input  wire logic [31:0] inst_addr,
	output logic             inst_ready,
	output logic      [31:0] inst_rdata,
	// Data
	input  wire logic        data_req,
	input  wire logic        data_we,
	input  wire logic        bus_hold_in,
	output logic      [31:0] data_rdata,
	output logic             memory_hold_in
);
	logic [31:0] imem [0:2047];
	logic        ld_pend;
	logic        held;
	initial begin
		inst_ready = 1'b0;
		inst_rdata = 32'h0000_0000;
		data_rdata = 32'h0000_0000;
		memory_hold_in = 1'b0;
	end
	// Load taken only on an edge with both holds low
	always @(negedge mclk) begin
		ld_pend = data_req & ~data_we & ~memory_hold_in & ~bus_hold_in;
		held = memory_hold_in | bus_hold_in;
	end
	// Idle lines show the inverse of their last value
	always @(posedge mclk) begin
		#2;
		inst_ready = slow ? 1'($urandom % 2) : 1'b1;
		inst_rdata = inst_ready ? imem[inst_addr[12:2]] : ~inst_rdata;
		// Load data stands while the pipeline is frozen
		data_rdata = ld_pend ? 32'h8001_1234 : held ? data_rdata : ~data_rdata;
		memory_hold_in = slow & data_req & ($urandom % 3 == 0);
	end
endmodule : rip_mem_model
`default_nettype wire

// File: sim/risc_integer_pipeline_control_tb.sv
// Purpose: Self-checking bench of the integer pipeline
// Assumes: Stores reveal register contents at the data port
// Notes:   Program runs once fast and once with stalls and holds
`timescale 1ns/1ps
`default_nettype none
module risc_integer_pipeline_control_tb;
	import rip_pkg::*;
	typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] m;} rip_exp_s;
	logic        mclk, resetn, slow, bus_hold_in, memory_hold_in, inst_ready, inst_req;
	logic        data_req, data_we, trap_taken, stall, trap_flag, async_trap_in;
	logic [31:0] inst_addr, inst_rdata, data_addr, data_wdata, data_rdata;
	logic [31:0] saved_pc, saved_npc, proc_state;
	logic [7:0]  trap_type, exp_tt;
	logic [1:0]  data_size;
	logic [31:0] stall_addr;
	rip_exp_s    exp_q[$];
	rip_exp_s    e;
	int          fails = 0;
	int          cmp_count = 0;
	int          traps;
	rip_pipe u_rip_pipe (.mclk(mclk), .resetn(resetn), .inst_addr(inst_addr),
		.inst_req(inst_req), .inst_ready(inst_ready), .inst_rdata(inst_rdata),
		.data_req(data_req), .data_we(data_we), .data_addr(data_addr),
		.data_wdata(data_wdata), .data_size(data_size), .data_rdata(data_rdata),
		.memory_hold_in(memory_hold_in), .bus_hold_in(bus_hold_in),
		.async_trap_in(async_trap_in), .trap_vector_base(32'h0000_1abc),
		.trap_taken(trap_taken), .trap_type(trap_type),
		.saved_pc(saved_pc), .saved_npc(saved_npc), .proc_state(proc_state));
	rip_mem_model u_rip_mem_model (.mclk(mclk), .slow(slow), .inst_addr(inst_addr),
		.inst_ready(inst_ready), .inst_rdata(inst_rdata), .data_req(data_req),
		.data_we(data_we), .bus_hold_in(bus_hold_in), .data_rdata(data_rdata),
		.memory_hold_in(memory_hold_in));
	function automatic logic [31:0] ins(input logic [3:0] op, input logic [4:0] rd,
		input logic [4:0] rs, input logic [3:0] fn, input logic [12:0] imm);
		return {op, rd, rs, 1'b1, fn, imm};
	endfunction : ins
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	task automatic run_prog();
		#2;
		resetn = 1'b0;
		async_trap_in = 1'b0;
		exp_tt = TT_ILLEGAL;
		exp_q.push_back('{32'h40, 32'h133, '1});
		exp_q.push_back('{32'h41, 32'h0030_0000, 32'h00ff_0000});
		exp_q.push_back('{32'h44, 32'hffff_8001, '1});
		exp_q.push_back('{32'h48, 32'h133, '1});
		exp_q.push_back('{32'h4c, 32'h55, '1});
		exp_q.push_back('{32'h54, 32'h123, '1});
		repeat (5) @(posedge mclk);
		#2;
		resetn = 1'b1;
		traps = 0;
		for (int i = 0; i < 600 && (exp_q.size() != 0 || traps == 0); i++) begin
			@(posedge mclk);
		end
		repeat (10) @(posedge mclk);
		chk(32'(exp_q.size()), 32'h0);
		chk(32'(traps), 32'h1);
		chk(proc_state, 32'h0);
		// Asynchronous trap request while the no-ops after the handler run
		#2;
		exp_tt = TT_ASYNC;
		async_trap_in = 1'b1;
		for (int i = 0; i < 50 && traps < 2; i++) begin
			@(posedge mclk);
		end
		#2;
		async_trap_in = 1'b0;
		repeat (2) @(posedge mclk);
		chk(32'(traps), 32'h2);
	endtask : run_prog
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Bus hold pulses in the slow pass
	always @(posedge mclk) begin
		#2;
		bus_hold_in = slow & ($urandom % 6 == 0);
	end
	// Monitor: stores against the oldest note, freezes and trap entry
	always @(negedge mclk) begin
		if (!resetn) begin
			stall = 1'b0;
			trap_flag = 1'b0;
		end else begin
			if (stall && !trap_taken) begin
				chk({31'h0, data_req}, 32'h1);
				chk(data_addr, stall_addr);
			end
			stall = data_req & (memory_hold_in | bus_hold_in);
			stall_addr = data_addr;
			if (data_req & data_we & ~stall) begin
				e = exp_q.size() != 0 ? exp_q.pop_front() : '{'1, '0, '0};
				chk(data_addr, e.a);
				chk(data_wdata & e.m, e.d);
				chk({30'h0, data_size}, {30'h0, e.m == '1 ? SZ_WORD : SZ_BYTE});
			end
			if (trap_flag) begin
				chk(inst_addr, {20'h0_0001, exp_tt, 4'h0});
				chk({31'h0, inst_req}, {31'h0, ~(memory_hold_in | bus_hold_in)});
				chk({24'h0, trap_type}, {24'h0, exp_tt});
				if (exp_tt == TT_ILLEGAL) begin
					chk(saved_pc, 32'h40);
					chk(saved_npc, 32'h44);
				end
			end
			trap_flag = trap_taken === 1'b1;
			traps += int'(trap_flag);
		end
	end
	initial begin
		#100000;
		fails++;
		tally_and_finish();
	end
	initial begin
		logic [31:0] prog [0:17];
		void'($urandom(21));
		resetn = 1'b0;
		slow = 1'b0;
		bus_hold_in = 1'b0;
		async_trap_in = 1'b0;
		prog = '{32'h4000_0002, 32'h7000_0000, ins(0, 1, 15, 4'h3, 13'h123),
			ins(0, 2, 1, 4'h0, 13'h10), ins(0, 3, 1, 4'h5, 13'h4), ins(2, 2, 15, 4'h2, 13'h40),
			ins(2, 3, 15, 4'h0, 13'h41), ins(1, 4, 15, 4'h5, 13'h80),
			ins(2, 4, 15, 4'h2, 13'h44), 32'h3800_0000, ins(0, 2, 15, 4'h9, 13'h1),
			ins(2, 2, 15, 4'h2, 13'h48), 32'h3400_0003, ins(0, 5, 15, 4'h3, 13'h55),
			ins(0, 5, 15, 4'h3, 13'h66), ins(2, 5, 15, 4'h2, 13'h4c), 32'hf000_0000,
			ins(2, 5, 15, 4'h2, 13'h50)};
		for (int i = 0; i < 2048; i++) begin
			u_rip_mem_model.imem[i] = i < 18 ? prog[i] : 32'h7000_0000;
		end
		u_rip_mem_model.imem[11'h408] = ins(2, 1, 15, 4'h2, 13'h54);
		for (int p = 0; p < 2; p++) begin
			slow = p[0];
			run_prog();
		end
		tally_and_finish();
	end
endmodule : risc_integer_pipeline_control_tb
`default_nettype wire
